// ### design/acs_regs.svh
// Constants for the converter control block and its host end
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_CLK_PERIOD_NS     50
`define ACS_DATA_W            14
`define ACS_CONV_MAX_NS       2200
`define ACS_CONV_CYC          (`ACS_CONV_MAX_NS / `ACS_CLK_PERIOD_NS)
`define ACS_NAP_WAKE_NS       400
`define ACS_NAP_WAKE_CYC      ((`ACS_NAP_WAKE_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_SLEEP_WAKE_MS     20
`define ACS_SLEEP_WAKE_CYC    ((`ACS_SLEEP_WAKE_MS * 1000000 + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_SAMPLE_RST        14'h0000
`define ACS_FIFO_DEPTH        16
`endif

// ### design/acs_pkg.sv
// Types shared by the converter control block and its host end
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_OUT_ALWAYS,
        ACS_OUT_STROBED,
        ACS_OUT_SLOW_MEM,
        ACS_OUT_ROM
    } acs_mode_type;
    typedef enum logic [1:0] {
        ACS_PWR_ACTIVE,
        ACS_PWR_NAP,
        ACS_PWR_SLEEP
    } acs_pwr_type;
endpackage

// ### design/acs_if.sv
// Parallel converter bus between the host and the converter control block
interface acs_if;
    logic        chip_sel_n;
    logic        read_n;
    logic        convert_start_n;
    logic        power_down_n;
    logic        busy_n;
    logic [13:0] data_out;
    logic        data_oe;
    modport dev  (input chip_sel_n, input read_n, input convert_start_n, input power_down_n,
                  output busy_n, output data_out, output data_oe);
    modport host (output chip_sel_n, output read_n, output convert_start_n, output power_down_n,
                  input busy_n, input data_out, input data_oe);
endinterface

// ### design/acs_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides
module acs_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // Fill side
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    // Drain side
    output logic [WIDTH-1:0]      o_rd_data,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } acs_fifo_st_type;

    logic [WIDTH-1:0] mem_q [DEPTH];
    acs_fifo_st_type  st_q;
    acs_fifo_st_type  st_d;
    logic             push;
    logic             pop;

    assign o_wr_ready = (st_q.cnt != (AW+1)'(DEPTH));
    assign o_rd_valid = (st_q.cnt != '0);
    assign o_rd_data  = mem_q[st_q.rp];
    assign push       = i_wr_valid && o_wr_ready;
    assign pop        = o_rd_valid && i_rd_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wp = st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
        if (push) begin
            mem_q[st_q.wp] <= i_wr_data;
        end
    end
endmodule

// ### design/acs_dev.sv
// Converter control end: conversion timing, busy, output enable and shutdown
// Functional notes
// R1: Low power-down input enters shutdown
// R2: Chip select low naps, high sleeps
// R3: Nap keeps reference; ready 400 ns later
// R4: Sleep drops reference; 20 ms wake
// R5: Convert-start low starts only with chip select
// R6: Starts ignored while converting
// R7: Busy low for whole conversion
// R8: Tied-low mode drives outputs continuously
// R9: Host may latch data at busy rise
// R10: Strobed mode floats outputs unless read
// R11: Slow memory: read starts, busy stalls, old data
// R12: Slow memory: new data then busy rises
// R13: ROM mode: read starts, returns previous result
// R14: Conversion done by internal clock within 2.2 us
// R15: Result is two's complement, 16384 levels
// R16: 14-bit result, no pipeline delay
`include "acs_regs.svh"
module acs_dev #(
    parameter int SLEEP_WAKE_CYC = `ACS_SLEEP_WAKE_CYC
) (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    // Bus pins
    acs_if.dev                           bus,
    // Sampled analog value, two's complement
    input  wire logic [`ACS_DATA_W-1:0]  i_sample,
    // Status
    output logic                         o_ref_ready,
    output logic                         o_shutdown
);
    typedef struct packed {
        logic [1:0]              cs_s;
        logic [1:0]              rd_s;
        logic [1:0]              cv_s;
        logic [1:0]              pd_s;
        logic                    cv_prev;
        logic                    converting;
        logic [6:0]              conv_cnt;
        logic [31:0]             wake_cnt;
        acs_pkg::acs_pwr_type    pwr;
        logic                    ref_ok;
        logic [`ACS_DATA_W-1:0]  result;
        logic                    busy_n;
        logic                    oe;
        logic                    shutdown;
    } acs_dev_st_type;

    acs_dev_st_type st_q;
    acs_dev_st_type st_d;

    assign bus.busy_n   = st_q.busy_n;
    assign bus.data_out = st_q.result;
    assign bus.data_oe  = st_q.oe;
    assign o_ref_ready  = st_q.ref_ok;
    assign o_shutdown   = st_q.shutdown;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser step: oldest stage sits in bit 1
    function automatic logic [1:0] sync_step(input logic [1:0] s, input logic pin);
        return {s[0], pin};
    endfunction

    // Wake time per shutdown flavour; nap keeps the reference so it is short
    function automatic logic [31:0] wake_cycles(input acs_pkg::acs_pwr_type pwr);
        logic [31:0] n;
        n = 32'h0;
        case (pwr)
            acs_pkg::ACS_PWR_NAP: begin
                n = 32'(`ACS_NAP_WAKE_CYC);
            end
            acs_pkg::ACS_PWR_SLEEP: begin
                n = 32'(SLEEP_WAKE_CYC);
            end
            default: begin
                n = 32'h0;
            end
        endcase
        return n;
    endfunction

    // Data bus is driven only while the host both selects and reads
    function automatic logic drives_bus(input logic cs_n, input logic rd_n);
        return !cs_n && !rd_n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic; every pin is read only after its second flop
    always_comb begin
        logic cs;
        logic rd;
        logic cv;
        logic pd;
        logic start;
        cs = st_q.cs_s[1];
        rd = st_q.rd_s[1];
        cv = st_q.cv_s[1];
        pd = st_q.pd_s[1];
        st_d = st_q;
        // Pins cross in through two flops
        st_d.cs_s    = sync_step(st_q.cs_s, bus.chip_sel_n);
        st_d.rd_s    = sync_step(st_q.rd_s, bus.read_n);
        st_d.cv_s    = sync_step(st_q.cv_s, bus.convert_start_n);
        st_d.pd_s    = sync_step(st_q.pd_s, bus.power_down_n);
        st_d.cv_prev = cv;

        // R5: falling edge with chip select
        start = st_q.cv_prev && !cv && !cs;

        // Wake count runs down on its own in every state
        if (st_q.wake_cnt != '0) begin
            st_d.wake_cnt = st_q.wake_cnt - 32'h1;
        end

        // A start seen during wake is dropped, not queued: the host must retry
        case (st_q.pwr)
            acs_pkg::ACS_PWR_ACTIVE: begin
                // R1: shutdown on low input
                if (!pd) begin
                    // Shutdown aborts a conversion; the old result stays
                    // R2: chip select picks flavour
                    st_d.pwr        = cs ? acs_pkg::ACS_PWR_SLEEP : acs_pkg::ACS_PWR_NAP;
                    st_d.converting = 1'b0;
                    st_d.busy_n     = 1'b1;
                    // R4: reference lost in sleep
                    if (cs) begin
                        st_d.ref_ok = 1'b0;
                    end
                // R6: busy blocks restart
                end else if (start && !st_q.converting && st_q.wake_cnt == '0) begin
                    st_d.converting = 1'b1;
                    st_d.conv_cnt   = 7'(`ACS_CONV_CYC - 1);
                    // R7: busy low for conversion
                    st_d.busy_n     = 1'b0;
                end else if (st_q.converting) begin
                    // R14: internal clock bounds time
                    if (st_q.conv_cnt == '0) begin
                        st_d.converting = 1'b0;
                        // R12: new data with busy rise
                        // R15: two's complement result
                        st_d.result     = i_sample;
                        st_d.busy_n     = 1'b1;
                    end else begin
                        st_d.conv_cnt = st_q.conv_cnt - 7'h1;
                    end
                end
            end
            acs_pkg::ACS_PWR_NAP: begin
                if (pd) begin
                    st_d.pwr = acs_pkg::ACS_PWR_ACTIVE;
                    // R3: nap wake delay
                    st_d.wake_cnt = wake_cycles(acs_pkg::ACS_PWR_NAP);
                end
            end
            acs_pkg::ACS_PWR_SLEEP: begin
                if (pd) begin
                    st_d.pwr = acs_pkg::ACS_PWR_ACTIVE;
                    // R4: reference settles 20 ms
                    st_d.wake_cnt = wake_cycles(acs_pkg::ACS_PWR_SLEEP);
                end
            end
            default: begin
                st_d.pwr = acs_pkg::ACS_PWR_ACTIVE;
            end
        endcase
        st_d.shutdown = (st_d.pwr != acs_pkg::ACS_PWR_ACTIVE);

        // After sleep, reference counts as ready only once the wake count has run out
        if (st_q.pwr == acs_pkg::ACS_PWR_ACTIVE && pd && st_q.wake_cnt == '0) begin
            st_d.ref_ok = 1'b1;
        end

        // R8: outputs on when read low
        // R10: three-state unless read
        // R11: prior result during busy
        // R13: ROM read returns previous result
        // R16: no pipeline on result
        st_d.oe = drives_bus(cs, rd);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronous reset; pin stages reset high so no false edge follows
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_q          <= '0;
            st_q.cs_s     <= 2'h3;
            st_q.rd_s     <= 2'h3;
            st_q.cv_s     <= 2'h3;
            st_q.pd_s     <= 2'h3;
            st_q.cv_prev  <= 1'b1;
            st_q.pwr      <= acs_pkg::ACS_PWR_ACTIVE;
            st_q.ref_ok   <= 1'b1;
            st_q.result   <= `ACS_SAMPLE_RST;
            st_q.busy_n   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ### design/acs_host.sv
// Host end: drives converter pins in a chosen mode and queues results
`include "acs_regs.svh"
module acs_host #(
    parameter int SLEEP_WAKE_CYC = `ACS_SLEEP_WAKE_CYC
) (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    // Bus pins
    acs_if.host                          bus,
    // User control
    input  wire acs_pkg::acs_mode_type   i_mode,
    input  wire logic                    i_start,
    input  wire logic                    i_shutdown,
    input  wire logic                    i_sleep,
    // Result stream
    output logic [`ACS_DATA_W-1:0]       o_data,
    output logic                         o_valid,
    input  wire logic                    i_ready,
    output logic                         o_idle
);
    typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_WAIT_BUSY, HS_WAIT_DONE, HS_SETTLE} acs_hs_type;
    typedef struct packed {
        acs_hs_type   fsm;
        logic [1:0]   bz_s;
        logic         cs_n;
        logic         rd_n;
        logic         cv_n;
        logic         pd_n;
        logic [31:0]  wait_cnt;
        logic [`ACS_DATA_W-1:0] cap;
        logic         push;
    } acs_host_st_type;

    acs_host_st_type st_q;
    acs_host_st_type st_d;
    logic            fifo_ready;

    assign bus.chip_sel_n      = st_q.cs_n;
    assign bus.read_n          = st_q.rd_n;
    assign bus.convert_start_n = st_q.cv_n;
    assign bus.power_down_n    = st_q.pd_n;
    assign o_idle              = (st_q.fsm == HS_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic bz;
        logic joined;
        bz     = st_q.bz_s[1];
        joined = (i_mode == acs_pkg::ACS_OUT_SLOW_MEM) || (i_mode == acs_pkg::ACS_OUT_ROM);
        st_d      = st_q;
        st_d.bz_s = {st_q.bz_s[0], bus.busy_n};
        st_d.push = 1'b0;
        if (st_q.wait_cnt != '0) begin
            st_d.wait_cnt = st_q.wait_cnt - 32'h1;
        end
        case (st_q.fsm)
            HS_IDLE: begin
                st_d.cs_n = i_shutdown && i_sleep;
                st_d.rd_n = (i_mode == acs_pkg::ACS_OUT_ALWAYS) ? 1'b0 : 1'b1;
                if (i_shutdown) begin
                    st_d.pd_n = 1'b0;
                end else if (!st_q.pd_n) begin
                    st_d.pd_n     = 1'b1;
                    st_d.wait_cnt = st_q.cs_n ? 32'(SLEEP_WAKE_CYC) : 32'(`ACS_NAP_WAKE_CYC + 4);
                end else if (i_start && st_q.wait_cnt == '0 && fifo_ready) begin
                    st_d.cv_n = 1'b0;
                    st_d.rd_n = joined ? 1'b0 : st_d.rd_n;
                    st_d.fsm  = HS_LOW;
                    st_d.wait_cnt = 32'h3;
                end
            end
            HS_LOW: begin
                if (st_q.wait_cnt == '0) begin
                    if (i_mode == acs_pkg::ACS_OUT_ROM) begin
                        st_d.cap  = bus.data_out;
                        st_d.push = 1'b1;
                        st_d.cv_n = 1'b1;
                        st_d.rd_n = 1'b1;
                    end else if (i_mode != acs_pkg::ACS_OUT_SLOW_MEM) begin
                        st_d.cv_n = 1'b1;
                    end
                    st_d.fsm = HS_WAIT_BUSY;
                    st_d.wait_cnt = 32'h4;
                end
            end
            HS_WAIT_BUSY: begin
                if (!bz || st_q.wait_cnt == '0) begin
                    st_d.fsm = HS_WAIT_DONE;
                end
            end
            HS_WAIT_DONE: begin
                if (bz) begin
                    // R9: latch result at busy rise
                    if (i_mode == acs_pkg::ACS_OUT_ALWAYS || i_mode == acs_pkg::ACS_OUT_SLOW_MEM) begin
                        st_d.cap  = bus.data_out;
                        st_d.push = 1'b1;
                        st_d.cv_n = 1'b1;
                        st_d.rd_n = (i_mode == acs_pkg::ACS_OUT_ALWAYS) ? 1'b0 : 1'b1;
                        st_d.fsm  = HS_IDLE;
                    end else if (i_mode == acs_pkg::ACS_OUT_STROBED) begin
                        st_d.rd_n     = 1'b0;
                        st_d.wait_cnt = 32'h3;
                        st_d.fsm      = HS_SETTLE;
                    end else begin
                        st_d.fsm = HS_IDLE;
                    end
                end
            end
            HS_SETTLE: begin
                if (st_q.wait_cnt == '0) begin
                    st_d.cap  = bus.data_out;
                    st_d.push = 1'b1;
                    st_d.rd_n = 1'b1;
                    st_d.fsm  = HS_IDLE;
                end
            end
            default: begin
                st_d.fsm = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_q      <= '0;
            st_q.fsm  <= HS_IDLE;
            st_q.bz_s <= 2'h3;
            st_q.cs_n <= 1'b0;
            st_q.rd_n <= 1'b1;
            st_q.cv_n <= 1'b1;
            st_q.pd_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Queue lets the user stall; host holds off new starts when full
    acs_fifo #(
        .WIDTH (`ACS_DATA_W),
        .DEPTH (`ACS_FIFO_DEPTH)
    ) u_fifo (
        .i_clk      (i_clk),
        .i_nrst     (i_nrst),
        .i_wr_data  (st_q.cap),
        .i_wr_valid (st_q.push),
        .o_wr_ready (fifo_ready),
        .o_rd_data  (o_data),
        .o_rd_valid (o_valid),
        .i_rd_ready (i_ready)
    );
endmodule

// ### sim/acs_assertions.sv
// Checker for the converter bus between the host end and the control end
module acs_assertions (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_nrst,
    // Bus pins
    input wire logic        chip_sel_n,
    input wire logic        read_n,
    input wire logic        convert_start_n,
    input wire logic        power_down_n,
    input wire logic        busy_n,
    input wire logic [13:0] data_out,
    input wire logic        data_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CONV = 44;
    logic [7:0] low_q;
    logic [7:0] up_q;
    logic [7:0] idle_q;
    ////////////////////////////////////////////////////////////////////////////
    // Counters: busy length, powered time, quiet time; the last two saturate to stay in range
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            low_q  <= 8'h00;
            up_q   <= 8'h00;
            idle_q <= 8'h00;
        end else begin
            low_q  <= busy_n ? 8'h00 : low_q + 8'h01;
            up_q   <= !power_down_n ? 8'h00 : ((up_q == 8'hff) ? up_q : up_q + 8'h01);
            idle_q <= (!busy_n || !power_down_n || chip_sel_n) ? 8'h00 :
                      ((idle_q == 8'hff) ? idle_q : idle_q + 8'h01);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_start_gives_busy: assert property ($fell(convert_start_n) && !chip_sel_n && idle_q > 8'h28
        |-> ##[3:5] !busy_n) else $error("busy did not fall after start");
    a_busy_has_cause: assert property ($fell(busy_n) |-> !$past(convert_start_n, 3) ||
        !$past(convert_start_n, 4) || !$past(convert_start_n, 5)) else $error("busy fell without start");
    a_busy_full_len: assert property ($rose(busy_n) && up_q > 8'h3c |-> low_q == CONV)
        else $error("conversion length wrong");
    a_busy_max_len: assert property (low_q <= CONV) else $error("conversion too long");
    a_data_at_done: assert property ($changed(data_out) |-> $rose(busy_n)) else $error("data moved mid conversion");
    a_oe_drives: assert property ((!chip_sel_n && !read_n) [*4] |-> data_oe) else $error("outputs not driven");
    a_oe_floats: assert property ((read_n || chip_sel_n) [*4] |-> !data_oe) else $error("outputs driven idle");
    a_shutdown_idle: assert property ((!power_down_n) [*4] |-> busy_n) else $error("busy in shutdown");
    a_wake_quiet: assert property ($rose(power_down_n) |-> busy_n [*8]) else $error("start during wake");
    c_full_conv: cover property ($rose(busy_n) && up_q > 8'h3c);
    c_wake: cover property ($rose(power_down_n));
    c_strobe_start: cover property ($fell(busy_n) && !read_n);
endmodule

// ### sim/tb_top.sv
// Testbench joining host end and control end across the converter bus
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE = 20;
    logic                  i_clk;
    logic                  i_nrst;
    logic                  i_start;
    logic                  i_shutdown;
    logic                  i_sleep;
    logic                  i_ready;
    logic                  o_valid;
    logic                  o_idle;
    logic                  o_ref_ready;
    logic                  o_shutdown;
    acs_pkg::acs_mode_type i_mode;
    logic [13:0]           i_sample;
    logic [13:0]           o_data;
    logic [13:0]           q[$];
    logic [13:0]           tbl[4] = '{14'h1fff, 14'h2000, 14'h3fff, 14'h0001};
    int                    error_cnt = 0;
    int                    checks_done = 0;
    acs_if bus ();
    acs_dev #(.SLEEP_WAKE_CYC(WAKE)) acs_dev_inst (.i_clk(i_clk), .i_nrst(i_nrst), .bus(bus),
        .i_sample(i_sample), .o_ref_ready(o_ref_ready), .o_shutdown(o_shutdown));
    acs_host #(.SLEEP_WAKE_CYC(WAKE)) acs_host_inst (.i_clk(i_clk), .i_nrst(i_nrst), .bus(bus),
        .i_mode(i_mode), .i_start(i_start), .i_shutdown(i_shutdown), .i_sleep(i_sleep),
        .o_data(o_data), .o_valid(o_valid), .i_ready(i_ready), .o_idle(o_idle));
    acs_assertions acs_assertions_inst (.i_clk(i_clk), .i_nrst(i_nrst), .chip_sel_n(bus.chip_sel_n),
        .read_n(bus.read_n), .convert_start_n(bus.convert_start_n), .power_down_n(bus.power_down_n),
        .busy_n(bus.busy_n), .data_out(bus.data_out), .data_oe(bus.data_oe));
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_w(input logic [13:0] got, input logic [13:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_w({13'h0000, got}, {13'h0000, exp});
    endtask
    // Inputs change 1 ns after the edge so no race with sampling
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Bounded wait on busy (which 0) or host idle (which 1)
    task automatic wait_on(input int which, input logic lvl, input int lim);
        int n;
        n = 0;
        while (((which == 0) ? bus.busy_n : o_idle) !== lvl && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) begin
            error_cnt++;
            $display("wrong value at %0t: waited %h limit %h", $time, n, lim);
            finish_test();
        end
    endtask
    task automatic conv(input logic [13:0] s);
        i_sample = s;
        i_start = 1'b1;
        wait_on(0, 1'b0, 200);
        i_start = 1'b0;
        wait_on(0, 1'b1, 100);
        chk_w(bus.data_out, s);
        wait_on(1, 1'b1, 100);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        i_nrst = 1'b0;
        i_mode = acs_pkg::ACS_OUT_ALWAYS;
        i_start = 1'b0;
        i_shutdown = 1'b0;
        i_sleep = 1'b0;
        i_ready = 1'b0;
        i_sample = 14'h0000;
        tick(5);
        i_nrst = 1'b1;
        tick(50);
        // Every output mode once, with boundary codes of the signed range
        for (int m = 0; m < 4; m++) begin
            i_mode = acs_pkg::acs_mode_type'(m);
            tick(50);
            conv(tbl[m]);
            // Output enable trails the read pin by three cycles
            tick(4);
            chk_b(bus.data_oe, m == 0);
            q.push_back((m == 3) ? tbl[2] : tbl[m]);
        end
        // Fill the queue to its depth, the host then holds starts back
        i_mode = acs_pkg::ACS_OUT_ALWAYS;
        for (int k = 4; k < 16; k++) begin
            tick(2);
            conv(14'(k * 1000));
            q.push_back(14'(k * 1000));
        end
        i_start = 1'b1;
        tick(100);
        chk_b(bus.busy_n, 1'b1);
        i_start = 1'b0;
        tick(5);
        while (q.size() > 0) begin
            chk_b(o_valid, 1'b1);
            chk_w(o_data, q.pop_front());
            i_ready = 1'b1;
            tick(1);
            i_ready = 1'b0;
            tick(1);
        end
        chk_b(o_valid, 1'b0);
        i_ready = 1'b1;
        // Nap requested mid conversion: host finishes it first, reference kept
        i_start = 1'b1;
        wait_on(0, 1'b0, 200);
        i_start = 1'b0;
        tick(5);
        i_shutdown = 1'b1;
        wait_on(1, 1'b1, 200);
        tick(10);
        chk_b(bus.busy_n, 1'b1);
        chk_b(o_shutdown, 1'b1);
        chk_b(bus.chip_sel_n, 1'b0);
        chk_b(o_ref_ready, 1'b1);
        i_shutdown = 1'b0;
        tick(50);
        conv(14'h0abc);
        // Sleep drops the reference until the wake count has run
        i_sleep = 1'b1;
        i_shutdown = 1'b1;
        tick(10);
        chk_b(bus.chip_sel_n, 1'b1);
        chk_b(bus.power_down_n, 1'b0);
        i_shutdown = 1'b0;
        tick(4);
        chk_b(o_ref_ready, 1'b0);
        tick(WAKE + 20);
        chk_b(o_ref_ready, 1'b1);
        i_sleep = 1'b0;
        conv(14'h2a55);
        tick(10);
        finish_test();
    end
endmodule
